// *** src/css_sequencer.sv ***
`timescale 1ns/1ps
module css_sequencer
(
    input  wire logic                 core_clk,  // 250 MHz clock
    input  wire logic                 rst_b,     // Sync reset, low
    input  css_pkg::css_flags_type    flagsIn,   // Raw comparator flags
    output css_pkg::css_ctl_type      loopCtl,   // Pin controls
    input  wire logic                 psel,      // APB select
    input  wire logic                 penable,   // APB enable
    input  wire logic                 pwrite,    // APB write
    input  wire logic [7:0]           paddr,     // APB byte address
    input  wire logic [31:0]          pwdata,    // APB write data
    output logic      [31:0]          prdata,    // APB read data
    output logic                      pready,    // APB ready
    output logic                      pslverr,   // APB error
    output logic                      irq        // Level interrupt
);
    import css_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    css_flags_type flagsSync;        // Synchronised flags
    css_state_type state_q;          // Present charge state
    css_state_type state_d;          // Next charge state
    css_ctl_type   ctl_d;            // Decoded next controls
    logic          forceTrickle_q;   // Software trickle override
    logic [3:0]    irqStatus_q;      // Sticky state entry events
    logic [3:0]    irqMask_q;        // Event enables
    logic [3:0]    entryEvt;         // Entry pulses, one per state
    logic          setupPh;          // APB setup cycle
    logic          accessWr;         // Write taking effect
    logic          accessRd;         // Read accepted

    // ------------------------------------------------------------
    // Address decode helper
    // ------------------------------------------------------------
    function automatic logic isMapped(input logic [7:0] a);
        isMapped = (a == CSS_CTRL_OFS) || (a == CSS_STATE_OFS) ||
                   (a == CSS_IRQST_OFS) || (a == CSS_IRQMSK_OFS);
    endfunction

    // ------------------------------------------------------------
    // Flag synchroniser
    // ------------------------------------------------------------
    css_sync #(
        .WIDTH   ($bits(css_flags_type))
    )
    u_sync
    (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .asyncIn  (flagsIn),
        .syncOut  (flagsSync)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        if (!flagsSync.chargeEnable || forceTrickle_q)
        begin
            state_d = CSS_TRICKLE;
        end
        else
        begin
            case (state_q)
                CSS_TRICKLE:
                begin
                    state_d = CSS_BULK;
                end
                CSS_BULK:
                begin
                    if (flagsSync.above95)
                    begin
                        state_d = CSS_OVER;
                    end
                end
                CSS_OVER:
                begin
                    if (flagsSync.taperLow)
                    begin
                        state_d = CSS_FLOAT;
                    end
                end
                CSS_FLOAT:
                begin
                    if (flagsSync.below90)
                    begin
                        state_d = CSS_BULK;
                    end
                end
                // Illegal code, recover to trickle
                default:
                begin
                    state_d = CSS_TRICKLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Output decode of next state
    // ------------------------------------------------------------
    css_decode u_decode
    (
        .state (state_d),
        .ctl   (ctl_d)
    );

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // reset enters trickle
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            state_q <= CSS_TRICKLE;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // Registered pin controls, in step with state
    // ------------------------------------------------------------
    // amp released past trickle
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            loopCtl             <= '0;
            loopCtl.vampDisable <= 1'b1;
            loopCtl.trickleBias <= 1'b1;
        end
        else
        begin
            loopCtl <= ctl_d;
        end
    end

    // ------------------------------------------------------------
    // APB phases
    // ------------------------------------------------------------
    assign setupPh  = psel && !penable;
    assign accessWr = psel && penable && pready && pwrite;
    assign accessRd = psel && penable && pready && !pwrite;

    // Ready and error answer one cycle after setup
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= setupPh;
            pslverr <= setupPh && !isMapped(paddr);
        end
    end

    // Read data captured in setup, stable in access
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            prdata <= '0;
        end
        else if (setupPh && !pwrite)
        begin
            case (paddr)
                CSS_CTRL_OFS:
                    prdata <= {31'h0000_0000, forceTrickle_q};
                CSS_STATE_OFS:
                    prdata <= {24'h00_0000, flagsSync, 2'h0, state_q};
                CSS_IRQST_OFS:
                    prdata <= {28'h000_0000, irqStatus_q};
                CSS_IRQMSK_OFS:
                    prdata <= {28'h000_0000, irqMask_q};
                // Unmapped reads return zero
                default:
                    prdata <= 32'h0000_0000;
            endcase
        end
        else if (accessRd)
        begin
            prdata <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            forceTrickle_q <= CSS_CTRL_RST[CSS_CTRL_FORCE_BIT];
        end
        else if (accessWr && paddr == CSS_CTRL_OFS)
        begin
            forceTrickle_q <= pwdata[CSS_CTRL_FORCE_BIT];
        end
    end

    // ------------------------------------------------------------
    // Interrupt mask
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            irqMask_q <= CSS_MASK_RST;
        end
        else if (accessWr && paddr == CSS_IRQMSK_OFS)
        begin
            irqMask_q <= pwdata[3:0];
        end
    end

    // ------------------------------------------------------------
    // Sticky events, set wins over write-one clear
    // ------------------------------------------------------------
    always_comb
    begin
        entryEvt = 4'h0;
        if (state_d != state_q)
        begin
            entryEvt[state_d] = 1'b1;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            irqStatus_q <= 4'h0;
        end
        else if (accessWr && paddr == CSS_IRQST_OFS)
        begin
            irqStatus_q <= (irqStatus_q & ~pwdata[3:0]) | entryEvt;
        end
        else
        begin
            irqStatus_q <= irqStatus_q | entryEvt;
        end
    end

    // Interrupt line, from a flop, one cycle behind status
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= |(irqStatus_q & irqMask_q);
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    sequence s_bulk;
        loopCtl.stateCodeBit0 && !loopCtl.stateCodeBit1;
    endsequence

    property p_trickle_pins;
        (state_q == CSS_TRICKLE) |-> !loopCtl.stateCodeBit0 &&
            !loopCtl.stateCodeBit1 && !loopCtl.floatFlag;
    endproperty
    a_trickle_pins: assert property (p_trickle_pins)
        else $error("trickle pins wrong");

    property p_bulk_pins;
        (state_q == CSS_BULK) |-> s_bulk and !loopCtl.floatFlag;
    endproperty
    a_bulk_pins: assert property (p_bulk_pins)
        else $error("bulk pins wrong");

    property p_over_pins;
        (state_q == CSS_OVER) |-> loopCtl.stateCodeBit1 &&
            !loopCtl.stateCodeBit0 && !loopCtl.floatFlag;
    endproperty
    a_over_pins: assert property (p_over_pins)
        else $error("overcharge pins wrong");

    property p_float_pins;
        (state_q == CSS_FLOAT) |-> loopCtl.stateCodeBit1 &&
            loopCtl.stateCodeBit0 && loopCtl.floatFlag;
    endproperty
    a_float_pins: assert property (p_float_pins)
        else $error("float pins wrong");

    property p_low_batt;
        !flagsSync.chargeEnable |=> state_q == CSS_TRICKLE &&
            !loopCtl.floatFlag;
    endproperty
    a_low_batt: assert property (p_low_batt)
        else $error("low battery did not force trickle");

    property p_trickle_exit;
        (state_q == CSS_TRICKLE && flagsSync.chargeEnable &&
            !forceTrickle_q) |=> s_bulk;
    endproperty
    a_trickle_exit: assert property (p_trickle_exit)
        else $error("trickle did not move to bulk");

    property p_bulk_exit;
        (state_q == CSS_BULK && flagsSync.chargeEnable &&
            !forceTrickle_q && flagsSync.above95)
            |=> state_q == CSS_OVER;
    endproperty
    a_bulk_exit: assert property (p_bulk_exit)
        else $error("bulk did not move to overcharge");

    property p_over_exit;
        (state_q == CSS_OVER && flagsSync.chargeEnable &&
            !forceTrickle_q && flagsSync.taperLow)
            |=> loopCtl.floatFlag;
    endproperty
    a_over_exit: assert property (p_over_exit)
        else $error("overcharge did not move to float");

    property p_float_exit;
        (state_q == CSS_FLOAT && flagsSync.chargeEnable &&
            !forceTrickle_q && flagsSync.below90) |=> s_bulk;
    endproperty
    a_float_exit: assert property (p_float_exit)
        else $error("float did not return to bulk");

    property p_amp_ctl;
        loopCtl.vampDisable == loopCtl.trickleBias &&
            loopCtl.vampDisable == (state_q == CSS_TRICKLE);
    endproperty
    a_amp_ctl: assert property (p_amp_ctl)
        else $error("amp controls disagree with state");

    property p_hold;
        (flagsSync.chargeEnable && !forceTrickle_q &&
            state_q == CSS_OVER && !flagsSync.taperLow)
            |=> $stable(state_q) && $stable(loopCtl);
    endproperty
    a_hold: assert property (p_hold)
        else $error("state moved without cause");
endmodule

// *** src/css_pkg.sv ***
// Functional notes
// - Trickle: both code bits and float low
// - Bulk: code bit0 high, others low
// - Overcharge: code bit1 high, others low
// - Float: both code bits and float high
// - Charge enable low holds trickle, float low
// - Trickle to bulk on charge enable
// - Bulk to overcharge above 95 percent
// - Overcharge to float on taper current
// - Float to bulk below 90 percent
// - Trickle: amp disabled, trickle bias steered
// - Bulk onward: voltage amp enabled
// - Float flag selects divider ratio
// - Charge enable acts as low battery detector
package css_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] CSS_CTRL_OFS   = 8'h00; // Control
    localparam logic [7:0] CSS_STATE_OFS  = 8'h04; // State and flags
    localparam logic [7:0] CSS_IRQST_OFS  = 8'h08; // Sticky events
    localparam logic [7:0] CSS_IRQMSK_OFS = 8'h0C; // Event mask

    // Field positions
    localparam int CSS_CTRL_FORCE_BIT = 0;   // Force trickle
    localparam int CSS_STATE_FLG_LSB  = 4;   // Synced flags in status

    // Reset values
    localparam logic [31:0] CSS_CTRL_RST = 32'h0000_0000;
    localparam logic [3:0]  CSS_MASK_RST = 4'h0;

    // Synchroniser depth
    localparam int CSS_SYNC_STAGES = 2;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    // Charge states, event bit index equals state order
    typedef enum logic [1:0]
    {
        CSS_TRICKLE,
        CSS_BULK,
        CSS_OVER,
        CSS_FLOAT
    } css_state_type;

    // Comparator flags from the analog loop
    typedef struct packed
    {
        logic chargeEnable;  // Battery above charge enable level
        logic above95;       // Battery above 95 percent of target
        logic taperLow;      // Charge current below taper level
        logic below90;       // Battery below 90 percent of float
    } css_flags_type;

    // Controls driven to the analog loop and status pins
    typedef struct packed
    {
        logic stateCodeBit1; // Decode bit one
        logic stateCodeBit0; // Decode bit zero
        logic floatFlag;     // Float state, also divider select
        logic vampDisable;   // Voltage error amp output high-Z
        logic trickleBias;   // Trickle bias into current amp input
    } css_ctl_type;

endpackage

// *** src/css_sync.sv ***
`timescale 1ns/1ps
module css_sync #(
    parameter int WIDTH = 4                  // Bits to synchronise
)
(
    input  wire logic             core_clk,  // System clock
    input  wire logic             rst_b,     // Sync reset, active low
    input  wire logic [WIDTH-1:0] asyncIn,   // Raw inputs
    output logic      [WIDTH-1:0] syncOut    // Synchronised inputs
);
    import css_pkg::*;

    logic [WIDTH-1:0] meta_q;                // First stage, read once

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (WIDTH < 1)
    begin : g_chk
        $error("css_sync: WIDTH must be at least one");
    end

    // ------------------------------------------------------------
    // Two flop chain
    // ------------------------------------------------------------
    // two flop synchroniser
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            meta_q  <= '0;
            syncOut <= '0;
        end
        else
        begin
            meta_q  <= asyncIn;
            syncOut <= meta_q;
        end
    end
endmodule

// *** src/css_decode.sv ***
`timescale 1ns/1ps
module css_decode
(
    input  css_pkg::css_state_type state,    // Charge state
    output css_pkg::css_ctl_type   ctl       // Decoded controls
);
    import css_pkg::*;

    // ------------------------------------------------------------
    // State to pin decode
    // ------------------------------------------------------------
    always_comb
    begin
        ctl = '0;
        case (state)
            CSS_TRICKLE:
            begin
                ctl.vampDisable = 1'b1;
                ctl.trickleBias = 1'b1;
            end
            CSS_BULK:
            begin
                ctl.stateCodeBit0 = 1'b1;
            end
            CSS_OVER:
            begin
                ctl.stateCodeBit1 = 1'b1;
            end
            CSS_FLOAT:
            begin
                ctl.stateCodeBit1 = 1'b1;
                ctl.stateCodeBit0 = 1'b1;
                ctl.floatFlag     = 1'b1;
            end
            // Unreachable encoding, safe trickle controls
            default:
            begin
                ctl.vampDisable = 1'b1;
                ctl.trickleBias = 1'b1;
            end
        endcase
    end
endmodule

// *** tb/css_battery_model.sv ***
`timescale 1ns/1ps
module css_battery_model #(
    parameter int CE_MV    = 2000,          // Charge enable level
    parameter int VOC_MV   = 2450,          // Overcharge target
    parameter int VF_MV    = 2250,          // Float target
    parameter int TAPER_MA = 100            // Taper current level
)
(
    input  wire logic              core_clk, // Clock
    input  wire logic [15:0]       battMv,   // Battery voltage
    input  wire logic [15:0]       currMa,   // Charge current
    input  css_pkg::css_ctl_type   loopCtl,  // Controls from design
    output css_pkg::css_flags_type flags     // Comparator flags
);
    import css_pkg::*;

    // Comparators settle one clock after the battery moves
    always @(posedge core_clk)
    begin
        flags.chargeEnable <= int'(battMv) > CE_MV;
        flags.above95      <= int'(battMv) * 100 > VOC_MV * 95;
        flags.taperLow     <= int'(currMa) < TAPER_MA;
        flags.below90      <= loopCtl.floatFlag
                              && int'(battMv) * 100 < VF_MV * 90;
    end
endmodule

// *** tb/charge_state_sequencer_tb.sv ***
`timescale 1ns/1ps
module charge_state_sequencer_tb;
    import css_pkg::*;

    logic          core_clk = 0;     // Clock
    logic          rst_b    = 0;     // Reset, active low
    logic          psel     = 0;     // APB select
    logic          penable  = 0;     // APB enable
    logic          pwrite   = 0;     // APB direction
    logic [7:0]    paddr    = 8'h00; // APB address
    logic [31:0]   pwdata   = '0;    // APB write data
    logic [31:0]   prdata;           // APB read data
    logic          pready;           // APB ready
    logic          pslverr;          // APB error
    logic          irq;              // Interrupt
    logic [15:0]   battMv   = '0;    // Model battery voltage
    logic [15:0]   currMa   = 16'h01F4; // Model current
    css_flags_type flags;            // Comparator flags
    css_ctl_type   loopCtl;          // Pin controls
    css_flags_type s1, s2;           // Reference sync chain
    css_state_type refSt;            // Reference state
    logic          refForce = 0;     // Reference force trickle
    logic          chkEn    = 0;     // Pin scoreboard on
    logic [31:0]   seed;             // Random source
    logic [31:0]   r;                // Read data
    logic          e;                // Error response
    int            errors   = 0;     // Mismatches
    int            n_checks = 0;     // Comparisons

    always #2 core_clk = ~core_clk;

    css_sequencer u_css_sequencer (.core_clk(core_clk), .rst_b(rst_b),
        .flagsIn(flags), .loopCtl(loopCtl), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq));

    css_battery_model u_css_battery_model (.core_clk(core_clk),
        .battMv(battMv), .currMa(currMa), .loopCtl(loopCtl),
        .flags(flags));

    // ------------------------------------------------------------
    // Reference model
    // ------------------------------------------------------------
    function automatic css_state_type nxt(css_state_type s,
                                          css_flags_type f);
        if (!f.chargeEnable)
            return CSS_TRICKLE;
        case (s)
            CSS_TRICKLE: return CSS_BULK;
            CSS_BULK:    return f.above95 ? CSS_OVER : s;
            CSS_OVER:    return f.taperLow ? CSS_FLOAT : s;
            default:     return f.below90 ? CSS_BULK : s;
        endcase
    endfunction

    // Pins per state: code1, code0, float, amp off, bias
    function automatic css_ctl_type dec(css_state_type s);
        case (s)
            CSS_TRICKLE: return 5'b00011;
            CSS_BULK:    return 5'b01000;
            CSS_OVER:    return 5'b10000;
            default:     return 5'b11100;
        endcase
    endfunction

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C1_1DB7 : 32'h0);
    endfunction

    // Two flop delay then one move per edge
    always @(posedge core_clk)
    begin
        s1 <= rst_b ? flags : '0;
        s2 <= rst_b ? s1 : '0;
        if (!rst_b || refForce)
            refSt <= CSS_TRICKLE;
        else
            refSt <= nxt(refSt, s2);
    end

    // Pins compared every cycle once settled
    always @(negedge core_clk)
        if (rst_b && chkEn)
            check({27'h0, loopCtl}, {27'h0, dec(refSt)}, "pins");

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] got, exp, input string m);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: %s got %h exp %h",
                     $time, m, got, exp);
        end
    endtask

    // One APB transfer, held until pready
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] rd,
                        output logic er);
        int n;
        n = 0;
        @(posedge core_clk);
        psel    <= 1;
        penable <= 0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
            check(0, 1, "apb hang");
        rd = prdata;
        er = pslverr;
        psel    <= 0;
        penable <= 0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1, a, d, r, e);
    endtask

    task automatic rdm(input logic [7:0] a, input logic [31:0] m, x,
                       input string s);
        xfer(0, a, 32'h0, r, e);
        check(r & m, x, s);
        check({31'h0, e}, 32'h0, "slverr");
    endtask

    task automatic setb(input int b, c, n);
        battMv <= 16'(b);
        currMa <= 16'(c);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic chk_irq(input logic x);
        @(negedge core_clk);
        check({31'h0, irq}, {31'h0, x}, "irq");
    endtask

    task automatic final_report;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Hang guard far beyond the planned run
    initial
    begin
        #40000;
        errors++;
        final_report;
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (10) @(posedge core_clk);
        rst_b <= 1;
        repeat (4) @(posedge core_clk);
        chkEn <= 1;
        rdm(CSS_CTRL_OFS, 32'hFFFF_FFFF, CSS_CTRL_RST, "ctrl");
        rdm(CSS_IRQMSK_OFS, 32'hF, {28'h0, CSS_MASK_RST}, "mask");
        rdm(CSS_STATE_OFS, 32'h3, 32'h0, "reset state");
        xfer(1, 8'h10, 32'hFFFF_FFFF, r, e);
        check({31'h0, e}, 32'h1, "unmapped wr");
        xfer(0, 8'h10, 32'h0, r, e);
        check({31'h0, e}, 32'h1, "unmapped rd");
        check(r, 32'h0, "unmapped data");
        $display("test registers done");
        wr(CSS_IRQST_OFS, 32'hF);
        wr(CSS_IRQMSK_OFS, 32'h2);
        setb(2100, 500, 8);
        rdm(CSS_STATE_OFS, 32'h3, 32'h1, "bulk");
        chk_irq(1);
        wr(CSS_IRQST_OFS, 32'h2);
        repeat (2) @(posedge core_clk);
        chk_irq(0);
        setb(2400, 500, 8);
        rdm(CSS_STATE_OFS, 32'h3, 32'h2, "over");
        chk_irq(0);
        setb(2400, 50, 8);
        rdm(CSS_STATE_OFS, 32'h3, 32'h3, "float");
        setb(2010, 50, 8);
        rdm(CSS_STATE_OFS, 32'h3, 32'h1, "rebulk");
        chk_irq(1);
        rdm(CSS_IRQST_OFS, 32'hE, 32'hE, "events");
        $display("test walk done");
        chkEn <= 0;
        wr(CSS_CTRL_OFS, 32'h1);
        refForce <= 1;
        repeat (4) @(posedge core_clk);
        chkEn <= 1;
        rdm(CSS_STATE_OFS, 32'h3, 32'h0, "forced");
        chkEn <= 0;
        wr(CSS_CTRL_OFS, 32'h0);
        refForce <= 0;
        repeat (4) @(posedge core_clk);
        chkEn <= 1;
        setb(1900, 500, 8);
        rdm(CSS_STATE_OFS, 32'h3, 32'h0, "low batt");
        $display("test force done");
        // Mid-run reset from bulk falls back to trickle
        setb(2100, 500, 8);
        rst_b <= 0;
        repeat (3) @(posedge core_clk);
        rst_b <= 1;
        rdm(CSS_STATE_OFS, 32'h3, 32'h0, "reset again");
        $display("test reset done");
        seed = 32'h3782_B89B;
        repeat (300)
        begin
            seed = lfsr(seed);
            setb(1800 + int'(seed[15:0]) % 800, int'(seed[23:16]) + 20,
                 1 + int'(seed[30:28]));
        end
        $display("test random done");
        final_report;
    end
endmodule
